// file: sbb_pkg.sv
package sbb_pkg;

    // ************************************************************
    // descriptor layout
    // ************************************************************
    localparam int unsigned DESC_W = 128;
    localparam int unsigned LEN_W = 32;
    localparam int unsigned BYTE_W = 8;

    typedef enum logic [3:0] {
        SBB_TYPE_DATA = 4'h0,
        SBB_TYPE_BUCKET = 4'h1,
        SBB_TYPE_SEG = 4'h2,
        SBB_TYPE_LAST = 4'h3,
        SBB_TYPE_VENDOR = 4'hF
    } sbb_type_t;

    localparam logic [3:0] SBB_RSVD_LO = 4'h4;
    localparam logic [3:0] SBB_RSVD_HI = 4'hE;
    localparam logic [3:0] SBB_ZERO_NIB = 4'h0;
    localparam logic [LEN_W-1:0] SBB_LEN_ZERO = 32'h0000_0000;

    // byte 15, bytes 14:12, bytes 11:8, bytes 7:0 from msb down
    typedef struct packed {
        logic [3:0] dtype;
        logic [3:0] zero_nib;
        logic [23:0] rsvd_hi;
        logic [LEN_W-1:0] length;
        logic [63:0] rsvd_addr;
    } sbb_desc_t;

    // ************************************************************
    // decode result
    // ************************************************************
    typedef struct packed {
        logic type_err;
        logic is_bucket;
        logic is_dest;
        logic [LEN_W-1:0] discard_len;
    } sbb_info_t;

    // ************************************************************
    // states and accounting
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DROP = 3'b010,
        ST_REPORT = 3'b100
    } sbb_state_t;

    localparam int unsigned ACCT_W = 48;
    localparam logic [ACCT_W-1:0] ACCT_ZERO = 48'h0000_0000_0000;
    localparam logic [ACCT_W-1:0] BYTES_PER_BEAT = 48'h0000_0000_0001;
    localparam logic [LEN_W-1:0] LEN_ONE = 32'h0000_0001;
    localparam logic [1:0] RST_SYNC_ZERO = 2'h0;

endpackage : sbb_pkg

// file: sbb_buf.sv
`timescale 1ns/1ps
module sbb_buf #(
    parameter int unsigned W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import sbb_pkg::*;

    // ************************************************************
    // two-entry buffer, head slot drives the output directly
    // ************************************************************
    logic [W-1:0] head_r;
    logic [W-1:0] tail_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    // refused at elaboration so a bad width never reaches the netlist
    if (W == 0) begin : g_bad_w
        $error("sbb_buf: W must be non-zero");
    end

    assign in_ready = (cnt_r != 2'd2);
    assign out_valid = (cnt_r != 2'd0);
    assign out_data = head_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 2'd0;
        end else begin
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            head_r <= '0;
            tail_r <= '0;
        end else begin
            // head refills from tail on a pop with two entries held, or from input when it would be empty
            if (pop && cnt_r == 2'd2) begin
                head_r <= tail_r;
            end else if (push && (cnt_r == 2'd0 || (pop && cnt_r == 2'd1))) begin
                head_r <= in_data;
            end
            if (push && ((cnt_r == 2'd1 && !pop) || cnt_r == 2'd2)) begin
                tail_r <= in_data;
            end
        end
    end

endmodule : sbb_buf

// file: sbb_desc_chk.sv
`timescale 1ns/1ps
module sbb_desc_chk (
    input sbb_pkg::sbb_desc_t desc,
    input wire logic is_dest,
    output sbb_pkg::sbb_info_t info
);
    import sbb_pkg::*;

    // ************************************************************
    // combinational decode of one descriptor
    // ************************************************************
    logic code_rsvd;
    logic code_bad;
    logic bucket;

    // reserved address and bytes 14:12 are never looked at
    assign bucket = (desc.dtype == SBB_TYPE_BUCKET);
    assign code_rsvd = (desc.dtype >= SBB_RSVD_LO) && (desc.dtype <= SBB_RSVD_HI);
    // vendor codes are not served here and count as errors
    assign code_bad = code_rsvd || (desc.dtype == SBB_TYPE_VENDOR);

    always_comb begin
        info.type_err = code_bad || (desc.zero_nib != SBB_ZERO_NIB);
        info.is_bucket = bucket;
        info.is_dest = is_dest;
        info.discard_len = SBB_LEN_ZERO;
        if (bucket && is_dest && !info.type_err) begin
            info.discard_len = desc.length;
        end
    end

endmodule : sbb_desc_chk

// file: sbb_decoder.sv
`timescale 1ns/1ps
module sbb_decoder #(
    parameter int unsigned LBC_W = 16,
    parameter int unsigned BLK_BYTES = 512
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    // descriptor request
    input wire logic desc_valid,
    output logic desc_ready,
    input sbb_pkg::sbb_desc_t desc,
    input wire logic desc_is_dest,
    // decode report
    output logic done_valid,
    output sbb_pkg::sbb_info_t done_info,
    // command accounting
    input wire logic cmd_start,
    input wire logic [LBC_W-1:0] logical_block_count,
    output logic [sbb_pkg::ACCT_W-1:0] acct_bytes,
    output logic [sbb_pkg::ACCT_W-1:0] acct_target,
    output logic acct_match,
    // source data in
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [sbb_pkg::BYTE_W-1:0] s_data,
    // data toward host memory
    output logic m_valid,
    input wire logic m_ready,
    output logic [sbb_pkg::BYTE_W-1:0] m_data,
    // drop progress
    output logic dropping,
    output logic [sbb_pkg::LEN_W-1:0] drop_remain
);
    import sbb_pkg::*;

    // the product of both must fit the accounting width
    if (LBC_W == 0 || LBC_W > 32) begin : g_bad_lbc
        $error("sbb_decoder: LBC_W out of range");
    end
    if (BLK_BYTES == 0 || BLK_BYTES > 65536) begin : g_bad_blk
        $error("sbb_decoder: BLK_BYTES out of range");
    end

    // ************************************************************
    // reset release
    // ************************************************************
    logic [1:0] rst_sync_r;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= RST_SYNC_ZERO;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_r[1];

    // ************************************************************
    // descriptor decode
    // ************************************************************
    sbb_info_t chk_info;
    sbb_info_t info_r;
    logic take;

    sbb_desc_chk u_chk (
        .desc(desc),
        .is_dest(desc_is_dest),
        .info(chk_info)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    sbb_state_t state_r;
    sbb_state_t state_nxt;
    logic [LEN_W-1:0] remain_r;
    logic [LEN_W-1:0] remain_nxt;
    logic drop_beat;
    logic done_valid_r;

    assign desc_ready = (state_r == ST_IDLE);
    assign take = desc_valid && desc_ready;
    assign drop_beat = (state_r == ST_DROP) && s_valid;

    always_comb begin
        state_nxt = state_r;
        remain_nxt = remain_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    remain_nxt = chk_info.discard_len;
                    if (chk_info.discard_len == SBB_LEN_ZERO) begin
                        // zero length, not a bucket, source list or error: report at once
                        state_nxt = ST_REPORT;
                    end else begin
                        state_nxt = ST_DROP;
                    end
                end
            end
            ST_DROP: begin
                if (drop_beat) begin
                    remain_nxt = remain_r - LEN_ONE;
                    if (remain_r == LEN_ONE) begin
                        state_nxt = ST_REPORT;
                    end
                end
            end
            ST_REPORT: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
                remain_nxt = SBB_LEN_ZERO;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            remain_r <= SBB_LEN_ZERO;
        end else begin
            state_r <= state_nxt;
            remain_r <= remain_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            info_r <= '0;
        end else if (take) begin
            info_r <= chk_info;
        end
    end

    // report pulses in the cycle the sequencer sits in report
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_valid_r <= 1'b0;
        end else begin
            done_valid_r <= (state_nxt == ST_REPORT);
        end
    end

    assign done_valid = done_valid_r;
    assign done_info = info_r;
    assign dropping = (state_r == ST_DROP);
    assign drop_remain = remain_r;

    // ************************************************************
    // data path
    // ************************************************************
    logic buf_in_valid;
    logic buf_in_ready;
    logic pass_beat;

    // dropped bytes never enter the buffer, so they cannot reach memory
    assign buf_in_valid = s_valid && (state_r != ST_DROP);
    // dropping never stalls the source; passing is gated by the buffer
    assign s_ready = (state_r == ST_DROP) ? 1'b1 : buf_in_ready;
    assign pass_beat = buf_in_valid && buf_in_ready;

    sbb_buf #(
        .W(BYTE_W)
    ) u_buf (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(s_data),
        .out_valid(m_valid),
        .out_ready(m_ready),
        .out_data(m_data)
    );

    // ************************************************************
    // logical block accounting
    // ************************************************************
    localparam logic [ACCT_W-1:0] BLK_BYTES_W = ACCT_W'(BLK_BYTES);

    logic [ACCT_W-1:0] acct_r;
    logic [ACCT_W-1:0] acct_nxt;
    logic [ACCT_W-1:0] target_r;
    logic acct_match_r;

    // only moved bytes and destination discards are counted;
    // a source-list bucket never drops, so it adds nothing
    always_comb begin
        acct_nxt = acct_r;
        if (cmd_start) begin
            acct_nxt = ACCT_ZERO;
        end else if (pass_beat || drop_beat) begin
            acct_nxt = acct_r + BYTES_PER_BEAT;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acct_r <= ACCT_ZERO;
            target_r <= ACCT_ZERO;
        end else begin
            acct_r <= acct_nxt;
            if (cmd_start) begin
                target_r <= ACCT_W'(logical_block_count) * BLK_BYTES_W;
            end
        end
    end

    // match is valid two cycles after the last counted beat, one after acct_bytes updates
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acct_match_r <= 1'b0;
        end else begin
            acct_match_r <= (acct_r == target_r) && !cmd_start;
        end
    end

    assign acct_bytes = acct_r;
    assign acct_target = target_r;
    assign acct_match = acct_match_r;

endmodule : sbb_decoder

// file: sbb_decoder_properties.sv
`timescale 1ns/1ps
module sbb_decoder_props (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic desc_valid,
    input wire logic desc_ready,
    input sbb_pkg::sbb_desc_t desc,
    input wire logic desc_is_dest,
    input wire logic done_valid,
    input sbb_pkg::sbb_info_t done_info,
    input wire logic cmd_start,
    input wire logic [sbb_pkg::ACCT_W-1:0] acct_bytes,
    input wire logic s_valid,
    input wire logic s_ready,
    input wire logic dropping,
    input wire logic [sbb_pkg::LEN_W-1:0] drop_remain
);
    import sbb_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_take;
        desc_valid && desc_ready;
    endsequence
    sequence s_beat;
        dropping && s_valid && s_ready;
    endsequence
    a_bad_zero: assert property (s_take ##0 desc.zero_nib != 4'h0
        |=> done_valid && done_info.type_err) else $error("zero nibble not flagged");
    a_rsvd_code: assert property (s_take ##0 desc.dtype >= 4'h4
        |=> done_info.type_err) else $error("reserved code accepted");
    a_bucket_seen: assert property (s_take ##0 desc.dtype == 4'h1 && desc.zero_nib == 4'h0
        |=> done_info.is_bucket && !done_info.type_err) else $error("bucket not seen");
    a_zero_len: assert property (s_take ##0 desc.length == 32'h0000_0000
        && desc.dtype == 4'h1 && desc.zero_nib == 4'h0 |=> done_valid && !dropping)
        else $error("zero length not done at once");
    a_drop_load: assert property (s_take ##0 desc.dtype == 4'h1 && desc.zero_nib == 4'h0
        && desc_is_dest && desc.length != 32'h0000_0000 |=> dropping
        && drop_remain == $past(desc.length) && done_info.discard_len == $past(desc.length))
        else $error("drop length wrong");
    a_src_none: assert property (s_take ##0 !desc_is_dest
        |=> done_valid && !dropping && done_info.discard_len == 32'h0000_0000)
        else $error("source list dropped");
    a_drop_step: assert property (s_beat ##0 drop_remain > 32'h0000_0001
        |=> dropping && drop_remain == $past(drop_remain) - 1) else $error("drop step wrong");
    a_drop_end: assert property (s_beat ##0 drop_remain == 32'h0000_0001
        |=> !dropping && done_valid) else $error("drop end wrong");
    a_drop_acct: assert property (s_beat ##0 !cmd_start
        |=> acct_bytes == $past(acct_bytes) + 1) else $error("drop not counted");
endmodule : sbb_decoder_props

bind sbb_decoder sbb_decoder_props i_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc), .desc_is_dest(desc_is_dest),
    .done_valid(done_valid), .done_info(done_info), .cmd_start(cmd_start),
    .acct_bytes(acct_bytes), .s_valid(s_valid), .s_ready(s_ready), .dropping(dropping),
    .drop_remain(drop_remain));

// file: sbb_host_mem.sv
`timescale 1ns/1ps
module sbb_host_mem (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic m_valid,
    input wire logic [7:0] m_data,
    output logic m_ready
);
    logic [7:0] mem [0:15];
    int n_got = 0;
    // a stalled memory takes nothing, so the buffer must hold the bytes
    assign m_ready = !stall;
    always @(posedge ref_clk) begin
        if (m_valid && m_ready) begin
            mem[n_got[3:0]] <= m_data;
            n_got <= n_got + 1;
        end
    end
endmodule : sbb_host_mem

// file: sbb_decoder_bench.sv
`timescale 1ns/1ps
module sbb_decoder_bench;
    import sbb_pkg::*;
    typedef struct packed {
        logic [3:0] dt;
        logic [3:0] nib;
        logic [31:0] len;
        logic dest;
        logic err;
        logic [31:0] disc;
    } sbb_row_t;
    sbb_row_t rows [5] = '{
        '{4'h1, 4'h0, 32'h0000_0003, 1'b1, 1'b0, 32'h0000_0003},
        '{4'h1, 4'h0, 32'h0000_0000, 1'b1, 1'b0, 32'h0000_0000},
        '{4'h1, 4'h0, 32'h0000_0005, 1'b0, 1'b0, 32'h0000_0000},
        '{4'h1, 4'h3, 32'h0000_0004, 1'b1, 1'b1, 32'h0000_0000},
        '{4'h0, 4'h0, 32'h0000_0007, 1'b1, 1'b0, 32'h0000_0000}};
    logic ref_clk = 0, reset_n = 0, desc_valid = 0, desc_is_dest = 0, cmd_start = 0;
    logic s_valid = 0, stall = 0;
    sbb_desc_t desc = '0;
    logic [7:0] s_data = 8'hEE;
    logic desc_ready, done_valid, acct_match, s_ready, m_valid, m_ready, dropping;
    sbb_info_t done_info;
    logic [ACCT_W-1:0] acct_bytes, acct_target;
    logic [15:0] lbc = 16'h0001;
    logic [7:0] m_data;
    logic [LEN_W-1:0] drop_remain;
    int n_mismatch = 0, checks_done = 0, n_drop = 0;
    sbb_decoder #(.LBC_W(16), .BLK_BYTES(8)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .desc_valid(desc_valid), .desc_ready(desc_ready), .desc(desc),
        .desc_is_dest(desc_is_dest), .done_valid(done_valid), .done_info(done_info),
        .cmd_start(cmd_start), .logical_block_count(lbc), .acct_bytes(acct_bytes),
        .acct_target(acct_target), .acct_match(acct_match), .s_valid(s_valid), .s_ready(s_ready),
        .s_data(s_data), .m_valid(m_valid), .m_ready(m_ready), .m_data(m_data),
        .dropping(dropping), .drop_remain(drop_remain));
    sbb_host_mem i_mem (.ref_clk(ref_clk), .stall(stall), .m_valid(m_valid), .m_data(m_data),
        .m_ready(m_ready));
    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic chk(input bit ok, input string msg);
        checks_done++;
        if (!ok) begin
            n_mismatch++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // feeds source bytes only while dropping, so any leak shows in memory
    task automatic run(input logic [3:0] dt, input logic [3:0] nib, input logic [31:0] len,
        input logic dest);
        int k;
        @(negedge ref_clk);
        desc = '{sbb_type_t'(dt), nib, 24'hA5_A5A5, len, 64'hFFFF_FFFF_FFFF_FFFF};
        desc_is_dest = dest;
        desc_valid = 1'b1;
        n_drop = 0;
        @(negedge ref_clk);
        desc_valid = 1'b0;
        for (k = 0; k < 50 && done_valid !== 1'b1; k++) begin
            s_valid = dropping;
            @(negedge ref_clk);
            if (s_valid) n_drop++;
        end
        s_valid = 1'b0;
        if (done_valid !== 1'b1) begin
            chk(0, "no report");
            summarize();
        end
    endtask : run
    task automatic send(input logic [7:0] b);
        int k;
        s_data = b;
        for (k = 0; k < 50 && s_ready !== 1'b1; k++) @(negedge ref_clk);
        if (s_ready !== 1'b1) begin
            chk(0, "source stalled");
            summarize();
        end
        @(negedge ref_clk);
    endtask : send
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        int c;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk(desc_ready === 1'b1 && m_valid === 1'b0 && dropping === 1'b0, "reset state");
        $display("test reset done");
        foreach (rows[i]) begin
            run(rows[i].dt, rows[i].nib, rows[i].len, rows[i].dest);
            chk(done_info.type_err === rows[i].err, "error flag");
            chk(done_info.discard_len === rows[i].disc, "length");
            chk(32'(n_drop) === rows[i].disc, "dropped count");
        end
        $display("test rows done");
        for (c = 0; c < 16; c++) begin
            run(c[3:0], 4'h0, 32'h0000_0000, 1'b1);
            chk(done_info.type_err === (c >= 4), "type code");
            chk(done_info.is_bucket === (c == 1), "bucket code");
        end
        chk(i_mem.n_got == 0, "dropped byte reached memory");
        $display("test codes done");
        @(negedge ref_clk);
        cmd_start = 1'b1;
        @(negedge ref_clk);
        cmd_start = 1'b0;
        run(4'h1, 4'h0, 32'h0000_0003, 1'b1);
        @(negedge ref_clk);
        stall = 1'b1;
        s_valid = 1'b1;
        send(8'h11);
        send(8'h22);
        chk(s_ready === 1'b0, "buffer not full");
        stall = 1'b0;
        send(8'h33);
        send(8'h44);
        send(8'h55);
        s_valid = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk(i_mem.n_got == 5 && i_mem.mem[0] === 8'h11 && i_mem.mem[4] === 8'h55, "memory");
        chk(acct_bytes === 48'h0000_0000_0008 && acct_match === 1'b1, "count");
        chk(acct_target === 48'h0000_0000_0008, "target");
        run(4'h1, 4'h0, 32'h0000_0005, 1'b0);
        repeat (2) @(negedge ref_clk);
        chk(acct_bytes === 48'h0000_0000_0008, "source counted");
        $display("test accounting done");
        summarize();
    end
endmodule : sbb_decoder_bench
